// [csp_cfg_port.sv]
// Purpose: configuration space decoder and identification word of a bus slave
// Assumes: one common rising-edge clock for bus and module; identifier pins hard-wired
// Notes:   only single transfers are answered; other locations of our space read zero
module csp_cfg_port #(
   parameter bit          HAS_SLAVE   = 1'b1,
   parameter logic [15:0] IMPL_FIELD  = 16'h0000, // arbitrary value
   parameter logic [7:0]  DEVICE_NUM  = 8'h01,    // arbitrary value
   parameter logic [3:0]  REVISION    = 4'h0,     // arbitrary value
   parameter logic [3:0]  VENDOR_NUM  = 4'h0      // arbitrary value
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [3:0]  MODULE_IDENTIFIER_INPUTS,
   input  wire logic        ADDR_STROBE_N,
   input  wire logic [63:0] AD_IN,
   output      logic [63:0] AD_OUT,
   output      logic        AD_OE,
   output      logic        READY_OUT_N,
   output      logic        READY_OE,
   output      logic [3:0]  MODULE_ID
);
   typedef struct packed {
      csp_pkg::csp_dec_state_t st;
      logic [3:0]              id_meta;
      logic [3:0]              id;
      logic [35:0]             addr;
      logic                    wr;
   } csp_dec_regs_t;

   csp_dec_regs_t s_ff;
   csp_dec_regs_t nxt_s;
   csp_drv_if     drv_bus ();

   // identification word, constant by construction so writes cannot alter it
   function automatic logic [31:0] id_word();
      logic [31:0] w;
      w = 32'h0000_0000;
      w[csp_pkg::IMPL_MSB:csp_pkg::IMPL_LSB] = IMPL_FIELD;
      w[csp_pkg::DEV_MSB:csp_pkg::DEV_LSB]   = DEVICE_NUM;
      w[csp_pkg::REV_MSB:csp_pkg::REV_LSB]   = REVISION;
      w[csp_pkg::VEND_MSB:csp_pkg::VEND_LSB] = VENDOR_NUM;
      return w;
   endfunction

   function automatic logic space_hit(input logic [35:0] a, input logic [3:0] id);
      space_hit = (a[csp_pkg::TOP_MSB:csp_pkg::TOP_LSB] == csp_pkg::CFG_TOP_BYTE)
                  && (a[csp_pkg::SPACE_MSB:csp_pkg::SPACE_LSB] == id);
   endfunction

   function automatic logic is_id_word(input logic [35:0] a);
      is_id_word = (a[csp_pkg::OFFS_MSB:csp_pkg::OFFS_LSB] == csp_pkg::IDW_WORD_OFFS);
   endfunction

   logic        hit;
   logic [63:0] rdata;

   always_comb begin
      hit = HAS_SLAVE && space_hit(s_ff.addr, s_ff.id);
      rdata = csp_pkg::AD_RESET;
      if (is_id_word(s_ff.addr)) begin
         rdata[31:0] = id_word();
      end
   end

   always_comb begin
      nxt_s         = s_ff;
      nxt_s.id_meta = MODULE_IDENTIFIER_INPUTS;
      nxt_s.id      = s_ff.id_meta;
      drv_bus.start   = 1'b0;
      drv_bus.is_read = ~s_ff.wr;
      drv_bus.rdata   = rdata;
      case (s_ff.st)
         csp_pkg::DEC_IDLE: begin
            // strobes while an answer is still on the pins are not ours to take
            if (!ADDR_STROBE_N && !drv_bus.busy) begin
               nxt_s.st   = csp_pkg::DEC_EVAL;
               nxt_s.addr = AD_IN[csp_pkg::ADDR_MSB:0];
               nxt_s.wr   = AD_IN[csp_pkg::WRITE_BIT];
            end
         end
         csp_pkg::DEC_EVAL: begin
            // a miss stays silent so the master's watchdog reports an empty slot
            drv_bus.start = hit;
            nxt_s.st      = csp_pkg::DEC_IDLE;
         end
         default: begin
            nxt_s.st = csp_pkg::DEC_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_ff.st      <= csp_pkg::DEC_IDLE;
         s_ff.id_meta <= 4'h0;
         s_ff.id      <= 4'h0;
         s_ff.addr    <= 36'h0_0000_0000;
         s_ff.wr      <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   csp_drv u_drv (
      .clk       (CLK),
      .nrst      (NRST),
      .bus       (drv_bus.drv),
      .ad_out    (AD_OUT),
      .ad_oe     (AD_OE),
      .rdy_out_n (READY_OUT_N),
      .rdy_oe    (READY_OE)
   );

   assign MODULE_ID = s_ff.id;
endmodule

// [csp_cfg_port_asserts.sv]
// Purpose: pin level checks of the configuration port
// Assumes: strobes at least six cycles apart
// Notes: the answer starts exactly two samples after the strobe
module csp_cfg_port_asserts #(
   parameter bit          HAS_SLAVE  = 1'b1,
   parameter logic [15:0] IMPL_FIELD = 16'h0000,
   parameter logic [7:0]  DEVICE_NUM = 8'h01,
   parameter logic [3:0]  REVISION   = 4'h0,
   parameter logic [3:0]  VENDOR_NUM = 4'h0
) (
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic [3:0]  MODULE_IDENTIFIER_INPUTS,
   input wire logic        ADDR_STROBE_N,
   input wire logic [63:0] AD_IN,
   input wire logic [63:0] AD_OUT,
   input wire logic        AD_OE,
   input wire logic        READY_OUT_N,
   input wire logic        READY_OE,
   input wire logic [3:0]  MODULE_ID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   logic sel;
   logic idw;
   assign sel = !ADDR_STROBE_N && AD_IN[35:24] == {8'hFF, MODULE_ID} && HAS_SLAVE;
   assign idw = sel && !AD_IN[36] && AD_IN[23:2] == 22'h3FFFFF;
   sequence s_ans(rd);
      READY_OE && !READY_OUT_N && AD_OE == rd ##1 READY_OE && READY_OUT_N && !AD_OE
      ##1 !READY_OE;
   endsequence
   property p_rd; sel && !AD_IN[36] |-> ##2 s_ans(1'b1); endproperty
   property p_wr; sel && AD_IN[36] |-> ##2 s_ans(1'b0); endproperty
   property p_word;
      idw |-> ##2 AD_OE && AD_OUT == {32'h0, IMPL_FIELD, DEVICE_NUM, REVISION, VENDOR_NUM};
   endproperty
   property p_miss; !ADDR_STROBE_N && !sel |=> (!READY_OE && !AD_OE)[*4]; endproperty
   property p_rdy; $fell(READY_OUT_N) |-> READY_OE ##1 READY_OE && READY_OUT_N ##1 !READY_OE;
   endproperty
   property p_oe; AD_OE |-> READY_OE && !READY_OUT_N; endproperty
   property p_oe1; $rose(AD_OE) |=> !AD_OE; endproperty
   property p_id;
      $stable(MODULE_IDENTIFIER_INPUTS)[*3] |-> MODULE_ID == MODULE_IDENTIFIER_INPUTS;
   endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   a_wr: assert property (p_wr) else $error("write not answered");
   a_word: assert property (p_word) else $error("bad id word");
   a_miss: assert property (p_miss) else $error("answer on miss");
   a_rdy: assert property (p_rdy) else $error("ready order");
   a_oe: assert property (p_oe) else $error("data without ready");
   a_oe1: assert property (p_oe1) else $error("data held too long");
   a_id: assert property (p_id) else $error("id not followed");
endmodule
bind csp_cfg_port csp_cfg_port_asserts #(.HAS_SLAVE(HAS_SLAVE), .IMPL_FIELD(IMPL_FIELD),
   .DEVICE_NUM(DEVICE_NUM), .REVISION(REVISION), .VENDOR_NUM(VENDOR_NUM)) i_chk (
   .CLK(CLK), .NRST(NRST), .MODULE_IDENTIFIER_INPUTS(MODULE_IDENTIFIER_INPUTS),
   .ADDR_STROBE_N(ADDR_STROBE_N), .AD_IN(AD_IN), .AD_OUT(AD_OUT), .AD_OE(AD_OE),
   .READY_OUT_N(READY_OUT_N), .READY_OE(READY_OE), .MODULE_ID(MODULE_ID));

// [csp_drv.sv]
// Purpose: sequences the ready strobe and address/data pins for one answer
// Assumes: the master keeps its own drivers off while we answer
// Notes:   every pin output comes straight from a flip-flop
module csp_drv (
   input  wire logic       clk,
   input  wire logic       nrst,
   csp_drv_if.drv          bus,
   output      logic [63:0] ad_out,
   output      logic        ad_oe,
   output      logic        rdy_out_n,
   output      logic        rdy_oe
);
   typedef struct packed {
      csp_pkg::csp_drv_state_t st;
      logic [63:0]             ad;
      logic                    ad_oe;
      logic                    rdy_n;
      logic                    rdy_oe;
   } csp_drv_regs_t;

   csp_drv_regs_t s_ff;
   csp_drv_regs_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      case (s_ff.st)
         csp_pkg::DRV_IDLE: begin
            nxt_s.rdy_oe = 1'b0;
            nxt_s.ad_oe  = 1'b0;
            if (bus.start) begin
               // enable and value in the same cycle, never an undriven low
               nxt_s.st     = csp_pkg::DRV_LOW;
               nxt_s.rdy_n  = 1'b0;
               nxt_s.rdy_oe = 1'b1;
               nxt_s.ad     = bus.rdata;
               nxt_s.ad_oe  = bus.is_read;
            end
         end
         csp_pkg::DRV_LOW: begin
            // ready goes high while still driven; data lines let go from a known level
            nxt_s.st     = csp_pkg::DRV_HIGH;
            nxt_s.rdy_n  = 1'b1;
            nxt_s.ad_oe  = 1'b0;
         end
         csp_pkg::DRV_HIGH: begin
            // the bus-busy line belongs to the master; this port never drives it
            nxt_s.st     = csp_pkg::DRV_IDLE;
            nxt_s.rdy_oe = 1'b0;
         end
         default: begin
            nxt_s.st     = csp_pkg::DRV_IDLE;
            nxt_s.rdy_oe = 1'b0;
            nxt_s.ad_oe  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_ff.st     <= csp_pkg::DRV_IDLE;
         s_ff.ad     <= csp_pkg::AD_RESET;
         s_ff.ad_oe  <= 1'b0;
         s_ff.rdy_n  <= 1'b1;
         s_ff.rdy_oe <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign bus.busy  = (s_ff.st != csp_pkg::DRV_IDLE);
   assign ad_out    = s_ff.ad;
   assign ad_oe     = s_ff.ad_oe;
   assign rdy_out_n = s_ff.rdy_n;
   assign rdy_oe    = s_ff.rdy_oe;
endmodule

// [csp_drv_if.sv]
// Purpose: carries an answer request from the decoder to the pin sequencer
// Assumes: single clock, start is a one-cycle pulse
// Notes:   busy stays high until the pins are released again
interface csp_drv_if;
   logic        start;
   logic        is_read;
   logic [63:0] rdata;
   logic        busy;
   modport dec (output start, output is_read, output rdata, input busy);
   modport drv (input start, input is_read, input rdata, output busy);
endinterface

// [csp_mst.sv]
// Purpose: bus master model, one strobe per request
// Assumes: the slave drives the lines only while its enable is high
// Notes: released lines flip every cycle so stale data never passes
module csp_mst (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [36:0] addr,
   input  wire logic [63:0] ad_out,
   input  wire logic        ad_oe,
   output      logic        strobe_n,
   output      logic [63:0] ad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] drv = 64'h0;
   logic        go_ff = 1'b0;
   always @(posedge clk) begin
      go_ff <= go;
      drv   <= go ? {27'h0, addr} : ~drv;
   end
   assign strobe_n = !go_ff;
   assign ad_in = ad_oe ? ad_out : drv;
endmodule

// [csp_pkg.sv]
// Purpose: shared constants and types for the configuration space port
// Assumes: 36-bit physical address carried in the low bits of the address phase
// Notes:   positions and codes of the design files live here; the checker and testbench repeat them as literals
package csp_pkg;
   localparam int          AD_W          = 64;
   localparam int          ID_W          = 4;
   localparam int          SPACE_COUNT   = 16;
   // address phase layout
   localparam int          ADDR_MSB      = 35;
   localparam int          TOP_MSB       = 35;
   localparam int          TOP_LSB       = 28;
   localparam int          SPACE_MSB     = 27;
   localparam int          SPACE_LSB     = 24;
   localparam int          OFFS_MSB      = 23;
   localparam int          OFFS_LSB      = 2;
   localparam int          WRITE_BIT     = 36;
   localparam logic [7:0]  CFG_TOP_BYTE  = 8'hFF;
   // word offset of the identification word inside a space (byte 0xFFFFFC)
   localparam logic [21:0] IDW_WORD_OFFS = 22'h3FFFFF;
   // identification word field positions
   localparam int          IMPL_MSB      = 31;
   localparam int          IMPL_LSB      = 16;
   localparam int          DEV_MSB       = 15;
   localparam int          DEV_LSB       = 8;
   localparam int          REV_MSB       = 7;
   localparam int          REV_LSB       = 4;
   localparam int          VEND_MSB      = 3;
   localparam int          VEND_LSB      = 0;
   localparam logic [63:0] AD_RESET      = 64'h0000_0000_0000_0000;

   typedef enum logic [2:0] {
      DRV_IDLE = 3'h1,
      DRV_LOW  = 3'h2,
      DRV_HIGH = 3'h4
   } csp_drv_state_t;

   typedef enum logic [1:0] {
      DEC_IDLE = 2'h1,
      DEC_EVAL = 2'h2
   } csp_dec_state_t;
endpackage

// [tb_config_space_port_register.sv]
// Purpose: probes every space, writes, reads and boot fetches
// Assumes: second instance has no slave side
// Notes: identifier is changed between rounds
module tb_config_space_port_register;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] WORD = 32'h5A5A_3C29; // arbitrary value
   logic CLK = 0, NRST = 0, go = 0, strobe_n, ad_oe, rdy_n, rdy_oe, ad_oe_b, rdy_n_b, rdy_oe_b;
   logic [36:0] addr = '0;
   logic [3:0]  id = 4'h0;
   logic [3:0]  mid;
   logic [63:0] ad_in, ad_out;
   int err_total = 0, num_checks = 0, cyc = 0, seed = 32'h564B9774;
   always #5 CLK = ~CLK;
   csp_mst i_csp_mst (.clk(CLK), .go(go), .addr(addr), .ad_out(ad_out), .ad_oe(ad_oe),
      .strobe_n(strobe_n), .ad_in(ad_in));
   csp_cfg_port #(.IMPL_FIELD(WORD[31:16]), .DEVICE_NUM(WORD[15:8]), .REVISION(WORD[7:4]),
      .VENDOR_NUM(WORD[3:0])) i_csp_cfg_port (.CLK(CLK), .NRST(NRST),
      .MODULE_IDENTIFIER_INPUTS(id), .ADDR_STROBE_N(strobe_n), .AD_IN(ad_in), .AD_OUT(ad_out),
      .AD_OE(ad_oe), .READY_OUT_N(rdy_n), .READY_OE(rdy_oe), .MODULE_ID(mid));
   csp_cfg_port #(.HAS_SLAVE(1'b0)) i_csp_cfg_port_b (.CLK(CLK), .NRST(NRST),
      .MODULE_IDENTIFIER_INPUTS(id), .ADDR_STROBE_N(strobe_n), .AD_IN(ad_in), .AD_OUT(),
      .AD_OE(ad_oe_b), .READY_OUT_N(rdy_n_b), .READY_OE(rdy_oe_b), .MODULE_ID());
   task summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [64:0] model(input logic [36:0] a);
      logic hit;
      hit = a[35:24] == {8'hFF, id};
      return {hit, (hit && !a[36] && a[23:2] == 22'h3FFFFF) ? {32'h0, WORD} : 64'h0};
   endfunction
   task acc(input logic [36:0] a);
      logic got, got_b, oe;
      logic [63:0] d;
      logic [63:0] nlow;
      logic [63:0] ndrv;
      logic [64:0] m;
      got = 0; got_b = 0; oe = 0; d = '0; m = model(a);
      nlow = '0;
      ndrv = '0;
      @(posedge CLK); #1 go = 1; addr = a;
      @(posedge CLK); #1 go = 0;
      repeat (8) begin
         @(posedge CLK); #1;
         // unknown ready values are carried into got so the compare sees them
         if ((rdy_oe & ~rdy_n) !== 1'b0) begin
            got = rdy_oe & ~rdy_n;
            d = ad_out;
            oe = ad_oe;
         end
         nlow = nlow + 64'(rdy_oe & ~rdy_n);
         ndrv = ndrv + 64'(rdy_oe);
         got_b = got_b | rdy_oe_b | ad_oe_b | !rdy_n_b;
      end
      chk("ack", {63'h0, got}, {63'h0, m[64]});
      if (!a[36]) chk("data", d, m[63:0]);
      chk("drive", {63'h0, oe}, {63'h0, m[64] & !a[36]});
      chk("slaveless", {63'h0, got_b}, 64'h0);
      chk("ready_low", nlow, {63'h0, m[64]});
      chk("ready_drv", ndrv, {62'h0, m[64], 1'b0});
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      logic [36:0] q[$];
      logic [31:0] r;
      repeat (5) @(posedge CLK);
      #1;
      chk("reset", {56'h0, rdy_oe, ad_oe, !rdy_n, rdy_oe_b, mid}, 64'h0);
      NRST = 1;
      for (int k = 0; k < 3; k++) begin
         id = (k == 2) ? 4'h0 : 4'($random(seed));
         r = $random(seed);
         repeat (4) @(posedge CLK);
         #1;
         chk("id", {60'h0, mid}, {60'h0, id});
         for (int n = 0; n < 16; n++) q.push_back({1'b0, 8'hFF, n[3:0], 24'hFFFFFC});
         q.push_back({1'b1, 8'hFF, id, 24'hFFFFFC});
         q.push_back({1'b0, 8'hFF, id, 24'hFFFFFC});
         q.push_back({1'b0, 8'hFF, id, r[21:1], 1'b0, 2'b00});
         q.push_back({1'b0, 8'hFE, id, 24'hFFFFFC});
         q.push_back({1'b0, 8'hFF, 4'h0, 24'h000000});
         while (q.size() > 0) acc(q.pop_front());
      end
      summarize();
   end
endmodule
